// File: core/qsw_defs.svh
// Constants for the quad switch mode and watchdog logic.
`ifndef QSW_DEFS_SVH
`define QSW_DEFS_SVH

// Serial frame layout.
`define QSW_FRAME_BITS     16
`define QSW_CNT_W          5
`define QSW_TOGGLE_POS     15
`define QSW_ADDR_HI        14
`define QSW_ADDR_LO        12

// Register addresses carried in the frame.
`define QSW_ADDR_OUT       3'h0
`define QSW_ADDR_DOG       3'h1
`define QSW_ADDR_THERM     3'h2
`define QSW_ADDR_TRIP      3'h3

// Defaults restored on fail-safe entry.
`define QSW_TRIP_LOW_RST   3'h0
`define QSW_TRIP_HIGH_RST  1'h0
`define QSW_BLANK_RST      3'h0
`define QSW_THERM_CFG_RST  4'h0

// Fail-safe selection codes and the output patterns they force.
`define QSW_FS_GROUND      2'h0
`define QSW_FS_LOW         2'h1
`define QSW_FS_MID         2'h2
`define QSW_FS_OPEN        2'h3
`define QSW_PAT_LOW        4'h0
`define QSW_PAT_MID        4'h1
`define QSW_PAT_OPEN       4'h5

// Timing: internal oscillator period and watchdog base multiple.
`define QSW_MCLK_HZ        10000000
`define QSW_OSC_NS         1000
`define QSW_OSC_DIV        ((`QSW_OSC_NS * (`QSW_MCLK_HZ / 1000000)) / 1000)
`define QSW_DOG_BASE_TICKS 10000
`define QSW_TICK_W         20
`define QSW_DIV_W          8

`endif

// File: core/qsw_pkg.sv
// Types shared by the quad switch mode and watchdog logic.
package qsw_pkg;

  typedef enum logic [1:0] {
    mode_sleep    = 2'b00,
    mode_normal   = 2'b01,
    mode_fault    = 2'b10,
    mode_failsafe = 2'b11
  } qsw_mode_t;

endpackage

// File: core/qsw_sync.sv
// Two-stage synchroniser for pins arriving from outside the mclk domain.
`timescale 1ns/10ps
module qsw_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Asynchronous inputs and their synchronised copies.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// File: core/qsw_dog_timer.sv
// Watchdog timer counted in internal oscillator ticks.
`timescale 1ns/10ps
`include "qsw_defs.svh"
module qsw_dog_timer #(
  parameter int OSC_DIV    = `QSW_OSC_DIV,
  parameter int BASE_TICKS = `QSW_DOG_BASE_TICKS
) (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Control.
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [1:0] period_sel,
  // One-cycle pulse when the period runs out.
  output logic            expired
);

  logic [`QSW_DIV_W-1:0]  div_reg;
  logic [`QSW_TICK_W-1:0] tick_reg;
  logic                   osc_tick;

  // Period is the base multiple doubled for each step of the selection.
  function automatic logic [`QSW_TICK_W-1:0] limit(input logic [1:0] sel);
    limit = `QSW_TICK_W'(BASE_TICKS) << sel;
  endfunction

  assign osc_tick = (div_reg == `QSW_DIV_W'(OSC_DIV - 1));

  always_ff @(posedge mclk) begin
    if (!rst_n || !run || restart || osc_tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + `QSW_DIV_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || !run || restart) begin
      tick_reg <= '0;
      expired  <= 1'b0;
    end else if (osc_tick) begin
      if (tick_reg >= limit(period_sel) - `QSW_TICK_W'(1)) begin
        tick_reg <= '0;
        expired  <= 1'b1;
      end else begin
        tick_reg <= tick_reg + `QSW_TICK_W'(1);
        expired  <= 1'b0;
      end
    end else begin
      expired <= 1'b0;
    end
  end

endmodule

// File: core/qsw_watchdog.sv
// Mode sequencing, watchdog, fail-safe and thermal shutdown of a quad switch.
//
// What this block does
// - Serial words shift both ways together, bit 15 first down to bit 0.
// - After power up and before any pin change the block sleeps.
// - Outside fail-safe, mode request and init both low means sleep with all outputs off.
// - In sleep every serially written setting acts as zero.
// - Init high with no fault is normal mode; fault flag high, watchdog runs.
// - A fault enters fault mode, pulls fault flag low, stops faulted outputs.
// - Unless selection grounded, a rise of either pin arms the watchdog.
// - Timeout is the base tick count doubled for each step of the programmed period selection.
// - Host toggles bit 15 within the timeout; then operation stays normal.
// - Expiry without a toggle enters fail-safe until reinitialised.
// - In fail-safe only the selection sets outputs; commands are ignored.
// - Selection codes: grounded off, low all off, mid out 0, open outs 0,2.
// - Fail-safe entry restores trip levels, blank time and thermal hold config.
// - Protections keep working in fail-safe with defaults; the watchdog stops.
// - Status bit 2 reads one in fail-safe, else zero.
// - Fail-safe ends when both pins fall together or selection is grounded.
// - Grounded selection disables both watchdog and fail-safe.
// - Each output has its own thermal detector stopping only that output.
// - Thermal shutdown latches by default; a per-output bit selects auto.
// - Latched: output stays off until cool and commanded off then on.
// - Non-latched: output returns by itself once the thermal signal clears.
// - Frames are exactly sixteen bits; input bits sampled on clock fall.
// - A received frame is written on the rising edge of chip select.
// - Status is loaded into the output shifter on chip select falling.
`timescale 1ns/10ps
`include "qsw_defs.svh"
module qsw_watchdog #(
  parameter int DOG_BASE_TICKS = `QSW_DOG_BASE_TICKS
) (
  // Clock and reset.
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Mode pins.
  input  wire logic              mode_req_in,
  input  wire logic              init_in,
  input  wire logic [1:0]        failsafe_select_in,
  // Direct controls and per-output detectors.
  input  wire logic [3:0]        direct_inputs,
  input  wire logic [3:0]        over_temp_in,
  input  wire logic [3:0]        other_fault_in,
  // Serial port.
  input  wire logic              cs_n,
  input  wire logic              sclk,
  input  wire logic              si,
  output logic                   so_out,
  output logic                   so_oe,
  // Switch drive and status.
  output logic [3:0]             switch_out,
  output logic                   fault_flag_n,
  output logic                   dog_expired_flag,
  output qsw_pkg::qsw_mode_t     mode_out,
  // Trip configuration for the analog current sensing.
  output logic [2:0]             low_trip_level,
  output logic                   high_trip_level,
  output logic [2:0]             trip_blank_time
);
  import qsw_pkg::*;

  // Synchronised pins.
  logic [18:0] pins_s;
  logic        cs_s;
  logic        sclk_s;
  logic        si_s;
  logic        mode_s;
  logic        init_s;
  logic [1:0]  fs_sel_s;
  logic [3:0]  direct_s;
  logic [3:0]  ot_s;
  logic [3:0]  ext_s;

  qsw_sync #(
    .W(19)
  ) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    // Select enters inverted so the flops' reset zero reads as an idle bus, not a false fall.
    .async_in ({~cs_n, sclk, si, mode_req_in, init_in, failsafe_select_in,
                direct_inputs, over_temp_in, other_fault_in}),
    .sync_out (pins_s)
  );

  assign cs_s     = ~pins_s[18];
  assign sclk_s   = pins_s[17];
  assign si_s     = pins_s[16];
  assign mode_s   = pins_s[15];
  assign init_s   = pins_s[14];
  assign fs_sel_s = pins_s[13:12];
  assign direct_s = pins_s[11:8];
  assign ot_s     = pins_s[7:4];
  assign ext_s    = pins_s[3:0];

  // Previous values for edge detection.
  logic cs_d_reg;
  logic sclk_d_reg;
  logic mode_d_reg;
  logic init_d_reg;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cs_d_reg   <= 1'b1;
      sclk_d_reg <= 1'b0;
      mode_d_reg <= 1'b0;
      init_d_reg <= 1'b0;
    end else begin
      cs_d_reg   <= cs_s;
      sclk_d_reg <= sclk_s;
      mode_d_reg <= mode_s;
      init_d_reg <= init_s;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic sclk_rise;
  logic pin_rise;
  logic both_fall;
  logic both_low;
  logic fs_grounded;

  assign cs_fall     = cs_d_reg & ~cs_s;
  assign cs_rise     = ~cs_d_reg & cs_s;
  assign sclk_fall   = ~cs_s & sclk_d_reg & ~sclk_s;
  assign sclk_rise   = ~cs_s & ~sclk_d_reg & sclk_s;
  assign pin_rise    = (~mode_d_reg & mode_s) | (~init_d_reg & init_s);
  assign both_fall   = mode_d_reg & init_d_reg & ~mode_s & ~init_s;
  assign both_low    = ~mode_s & ~init_s;
  assign fs_grounded = (fs_sel_s == `QSW_FS_GROUND);

  // Mode state.
  qsw_mode_t mode_reg;
  qsw_mode_t mode_next;
  logic      armed_reg;
  logic      dog_expire;
  logic      fault_present;
  logic      in_sleep;
  logic      in_failsafe;

  assign in_sleep    = (mode_reg == mode_sleep);
  assign in_failsafe = (mode_reg == mode_failsafe);

  // Serial receive and transmit.
  logic [15:0]            rx_reg;
  logic [15:0]            tx_reg;
  logic [`QSW_CNT_W-1:0]  bit_cnt_reg;
  logic                   frame_done;
  logic                   last_toggle_reg;
  logic                   dog_restart;
  logic [2:0]             frame_addr;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx_reg      <= 16'h0000;
      bit_cnt_reg <= '0;
    end else if (cs_fall) begin
      bit_cnt_reg <= '0;
    end else if (sclk_fall) begin
      rx_reg      <= {rx_reg[14:0], si_s};
      if (bit_cnt_reg != `QSW_CNT_W'(`QSW_FRAME_BITS + 1)) begin
        bit_cnt_reg <= bit_cnt_reg + `QSW_CNT_W'(1);
      end
    end
  end

  // Overlong or short frames are dropped so a glitch cannot write settings.
  assign frame_done = cs_rise && (bit_cnt_reg == `QSW_CNT_W'(`QSW_FRAME_BITS));
  assign frame_addr = rx_reg[`QSW_ADDR_HI:`QSW_ADDR_LO];

  // Status word; bit 2 reports fail-safe.
  function automatic logic [15:0] status_word(input logic [3:0] hold,
                                              input logic [3:0] outs,
                                              input logic       flt,
                                              input logic       fsafe,
                                              input logic [1:0] sel);
    status_word = {4'h0, hold, outs, flt, fsafe, sel};
  endfunction

  logic [3:0] therm_hold_reg;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_reg <= 16'h0000;
      so_out <= 1'b0;
      so_oe  <= 1'b0;
    end else begin
      so_oe <= ~cs_s;
      if (cs_fall) begin
        tx_reg <= status_word(therm_hold_reg, switch_out, ~fault_flag_n,
                              in_failsafe, fs_sel_s);
        so_out <= 1'b0;
      end else if (sclk_rise) begin
        so_out <= tx_reg[15];
        tx_reg <= {tx_reg[14:0], 1'b0};
      end
    end
  end

  // Watchdog toggle tracking.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      last_toggle_reg <= 1'b0;
    end else if (frame_done) begin
      last_toggle_reg <= rx_reg[`QSW_TOGGLE_POS];
    end
  end

  assign dog_restart = pin_rise ||
                       (frame_done && (rx_reg[`QSW_TOGGLE_POS] != last_toggle_reg));

  // Settings written over the serial port.
  logic [3:0] out_cmd_reg;
  logic [1:0] dog_period_select;
  logic [3:0] thermal_hold_cfg;

  always_ff @(posedge mclk) begin
    if (!rst_n || in_sleep) begin
      out_cmd_reg       <= 4'h0;
      dog_period_select <= 2'h0;
    end else if (frame_done) begin
      if (frame_addr == `QSW_ADDR_OUT) begin
        out_cmd_reg <= rx_reg[3:0];
      end
      if (frame_addr == `QSW_ADDR_DOG) begin
        dog_period_select <= rx_reg[1:0];
      end
    end
  end

  // Trip and thermal settings fall back to defaults on fail-safe entry.
  always_ff @(posedge mclk) begin
    if (!rst_n || in_sleep) begin
      low_trip_level   <= 3'h0;
      high_trip_level  <= 1'h0;
      trip_blank_time  <= 3'h0;
      thermal_hold_cfg <= 4'h0;
    end else if (mode_next == mode_failsafe && !in_failsafe) begin
      low_trip_level   <= `QSW_TRIP_LOW_RST;
      high_trip_level  <= `QSW_TRIP_HIGH_RST;
      trip_blank_time  <= `QSW_BLANK_RST;
      thermal_hold_cfg <= `QSW_THERM_CFG_RST;
    end else if (frame_done) begin
      if (frame_addr == `QSW_ADDR_THERM) begin
        thermal_hold_cfg <= rx_reg[3:0];
      end
      if (frame_addr == `QSW_ADDR_TRIP) begin
        low_trip_level  <= rx_reg[2:0];
        high_trip_level <= rx_reg[3];
        trip_blank_time <= rx_reg[6:4];
      end
    end
  end

  // Watchdog arming. The waking rise is seen while the mode is still sleep, so it must win.
  always_ff @(posedge mclk) begin
    if (!rst_n || fs_grounded) begin
      armed_reg <= 1'b0;
    end else if (pin_rise) begin
      armed_reg <= 1'b1;
    end else if (in_sleep) begin
      armed_reg <= 1'b0;
    end
  end

  qsw_dog_timer #(
    .OSC_DIV    (`QSW_OSC_DIV),
    .BASE_TICKS (DOG_BASE_TICKS)
  ) u_dog (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .run        (armed_reg && !fs_grounded && !in_failsafe),
    .restart    (dog_restart),
    .period_sel (dog_period_select),
    .expired    (dog_expire)
  );

  // Fail-safe output pattern.
  function automatic logic [3:0] fs_pattern(input logic [1:0] sel);
    unique case (sel)
      `QSW_FS_GROUND: fs_pattern = 4'h0;
      `QSW_FS_LOW:    fs_pattern = `QSW_PAT_LOW;
      `QSW_FS_MID:    fs_pattern = `QSW_PAT_MID;
      `QSW_FS_OPEN:   fs_pattern = `QSW_PAT_OPEN;
    endcase
  endfunction

  // Commanded output state.
  logic [3:0] cmd_eff;

  always_comb begin
    if (in_failsafe) begin
      cmd_eff = fs_pattern(fs_sel_s);
    end else begin
      cmd_eff = out_cmd_reg | direct_s;
    end
  end

  // Thermal shutdown, one per output; a new over-temperature wins over release.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      therm_hold_reg <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (ot_s[i]) begin
          therm_hold_reg[i] <= 1'b1;
        end else if (thermal_hold_cfg[i]) begin
          therm_hold_reg[i] <= 1'b0;
        end else if (!cmd_eff[i]) begin
          therm_hold_reg[i] <= 1'b0;
        end
      end
    end
  end

  assign fault_present = |(therm_hold_reg | ot_s | ext_s);

  // Mode sequencing.
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      mode_failsafe: begin
        if (fs_grounded || both_fall) begin
          mode_next = both_low ? mode_sleep
                    : (fault_present ? mode_fault : mode_normal);
        end
      end
      mode_sleep, mode_normal, mode_fault: begin
        if (both_low) begin
          mode_next = mode_sleep;
        end else if (dog_expire && armed_reg && !fs_grounded) begin
          mode_next = mode_failsafe;
        end else if (fault_present) begin
          mode_next = mode_fault;
        end else begin
          mode_next = mode_normal;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_reg <= mode_sleep;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Registered outputs.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      switch_out       <= 4'h0;
      fault_flag_n     <= 1'b1;
      dog_expired_flag <= 1'b0;
      mode_out         <= mode_sleep;
    end else begin
      if (in_sleep) begin
        switch_out <= 4'h0;
      end else begin
        switch_out <= cmd_eff & ~therm_hold_reg & ~ot_s & ~ext_s;
      end
      fault_flag_n     <= in_sleep | ~fault_present;
      dog_expired_flag <= in_failsafe;
      mode_out         <= mode_reg;
    end
  end

endmodule

// File: tb/qsw_watchdog_properties.sv
// Port-level assertions for the quad switch mode and watchdog block.
`timescale 1ns/10ps
module qsw_watchdog_props (
  // Clock and reset.
  input  wire logic               mclk,
  input  wire logic               rst_n,
  // Pins.
  input  wire logic               mode_req_in,
  input  wire logic               init_in,
  input  wire logic [1:0]         failsafe_select_in,
  input  wire logic [3:0]         over_temp_in,
  input  wire logic [3:0]         other_fault_in,
  // Outputs under watch.
  input  wire logic [3:0]         switch_out,
  input  wire logic               fault_flag_n,
  input  wire logic               dog_expired_flag,
  input  wire qsw_pkg::qsw_mode_t mode_out,
  input  wire logic [2:0]         low_trip_level,
  input  wire logic               high_trip_level,
  input  wire logic [2:0]         trip_blank_time
);
  import qsw_pkg::*;
  logic [3:0] bad;
  logic [3:0] held_q [0:4];
  assign bad = over_temp_in | other_fault_in;
  // A detector must be held past the synchronisers and output register before we judge.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      held_q <= '{default: 4'h0};
    end else begin
      held_q[0] <= bad;
      for (int i = 1; i < 5; i++) begin
        held_q[i] <= held_q[i-1] & bad;
      end
    end
  end
  function automatic logic [3:0] pat(input logic [1:0] sel);
    return (sel == 2'h3) ? 4'h5 : (sel == 2'h2) ? 4'h1 : 4'h0;
  endfunction
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sleep_outputs_off_a: assert property ((mode_out == mode_sleep)[*2] |-> switch_out == 4'h0)
    else $error("outputs on while asleep");
  sleep_settings_zero_a: assert property ((mode_out == mode_sleep)[*2] |->
    {low_trip_level, high_trip_level, trip_blank_time} == 7'h00) else $error("settings kept in sleep");
  pins_low_sleep_a: assert property ((!mode_req_in && !init_in && mode_out != mode_failsafe)[*6]
    |-> mode_out == mode_sleep) else $error("pins low without sleep");
  // The flag is one cycle ahead of the reported mode, so it is judged one sample back.
  normal_flag_high_a: assert property ((mode_out == mode_normal)[*2] |-> $past(fault_flag_n))
    else $error("fault flag low in normal mode");
  fault_flag_low_a: assert property ((mode_out == mode_fault)[*2] |-> !$past(fault_flag_n))
    else $error("fault flag high in fault mode");
  expired_set_a: assert property ((mode_out == mode_failsafe)[*2] |-> dog_expired_flag)
    else $error("expired flag low in fail-safe");
  expired_clear_a: assert property ((mode_out != mode_failsafe)[*2] |-> !dog_expired_flag)
    else $error("expired flag high outside fail-safe");
  ground_no_failsafe_a: assert property ((failsafe_select_in == 2'h0)[*6]
    |-> mode_out != mode_failsafe) else $error("fail-safe with grounded selection");
  failsafe_pattern_a: assert property ((mode_out == mode_failsafe && $stable(failsafe_select_in))[*4]
    |-> (switch_out & ~pat(failsafe_select_in)) == 4'h0) else $error("output outside pattern");
  faulted_output_off_a: assert property ((switch_out & held_q[4] & bad) == 4'h0)
    else $error("faulted output still on");
endmodule
bind qsw_watchdog qsw_watchdog_props u_props (.mclk(mclk), .rst_n(rst_n),
  .mode_req_in(mode_req_in), .init_in(init_in), .failsafe_select_in(failsafe_select_in),
  .over_temp_in(over_temp_in), .other_fault_in(other_fault_in), .switch_out(switch_out),
  .fault_flag_n(fault_flag_n), .dog_expired_flag(dog_expired_flag), .mode_out(mode_out),
  .low_trip_level(low_trip_level), .high_trip_level(high_trip_level),
  .trip_blank_time(trip_blank_time));

// File: tb/qsw_host_model.sv
// Serial host model that frames sixteen-bit transfers for the switch block.
`timescale 1ns/10ps
module qsw_host_model (
  // Bench clock.
  input  wire logic mclk,
  // Serial lines toward the switch block.
  output logic      cs_n,
  output logic      sclk,
  output logic      si,
  input  wire logic so_out,
  input  wire logic so_oe
);
  initial begin
    cs_n = 1'h1;
    sclk = 1'h0;
    si   = 1'h0;
  end
  // Four mclk per half period gives the 800 ns link clock; it rests low between frames.
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    @(posedge mclk);
    cs_n <= 1'h0;
    repeat (4) @(posedge mclk);
    for (int i = 15; i >= 0; i--) begin
      sclk <= 1'h1;
      si   <= tx[i];
      repeat (4) @(posedge mclk);
      rx[i] = so_oe ? so_out : 1'h0;
      sclk <= 1'h0;
      repeat (4) @(posedge mclk);
    end
    cs_n <= 1'h1;
    si   <= 1'h0;
    repeat (8) @(posedge mclk);
  endtask
endmodule

// File: tb/qsw_watchdog_bench.sv
// Self-checking bench for the quad switch mode and watchdog block.
`timescale 1ns/10ps
`define QSW_CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module qsw_watchdog_bench;
  import qsw_pkg::*;
  logic        mclk = 1'h0;
  logic        rst_n = 1'h0;
  logic        mode_req_in = 1'h0;
  logic        init_in = 1'h0;
  logic [1:0]  failsafe_select_in = 2'h3;
  logic [3:0]  direct_inputs = 4'h0;
  logic [3:0]  over_temp_in = 4'h0;
  logic [3:0]  other_fault_in = 4'h0;
  logic        cs_n;
  logic        sclk;
  logic        si;
  logic        so_out;
  logic        so_oe;
  logic [3:0]  switch_out;
  logic        fault_flag_n;
  logic        dog_expired_flag;
  qsw_mode_t   mode_out;
  logic [2:0]  low_trip_level;
  logic        high_trip_level;
  logic [2:0]  trip_blank_time;
  int          miscompares = 0;
  int          n_checks = 0;
  logic        tog = 1'h0;
  logic [31:0] seed = 32'hA822;
  logic [15:0] rx;
  logic [3:0]  d;
  always #50 mclk = ~mclk;
  // A short base count keeps the fail-safe timeouts to a few hundred cycles.
  qsw_watchdog #(.DOG_BASE_TICKS(40)) DUT (.mclk(mclk), .rst_n(rst_n),
    .mode_req_in(mode_req_in), .init_in(init_in), .failsafe_select_in(failsafe_select_in),
    .direct_inputs(direct_inputs), .over_temp_in(over_temp_in), .other_fault_in(other_fault_in),
    .cs_n(cs_n), .sclk(sclk), .si(si), .so_out(so_out), .so_oe(so_oe), .switch_out(switch_out),
    .fault_flag_n(fault_flag_n), .dog_expired_flag(dog_expired_flag), .mode_out(mode_out),
    .low_trip_level(low_trip_level), .high_trip_level(high_trip_level),
    .trip_blank_time(trip_blank_time));
  qsw_host_model u_host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .si(si), .so_out(so_out),
    .so_oe(so_oe));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [3:0] fs_pat(input logic [1:0] sel);
    return (sel == 2'h3) ? 4'h5 : (sel == 2'h2) ? 4'h1 : 4'h0;
  endfunction
  // Every frame flips the toggle bit so the watchdog sees a live host.
  task automatic send(input logic [2:0] addr, input logic [11:0] data);
    tog = ~tog;
    u_host.xfer({tog, addr, data}, rx);
  endtask
  task automatic settle();
    repeat (10) @(posedge mclk);
  endtask
  task automatic final_report();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    miscompares++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'h1;
    repeat (3) @(posedge mclk);
    `QSW_CHK(mode_out, mode_sleep)
    `QSW_CHK({switch_out, fault_flag_n, dog_expired_flag}, 6'h02)
    $display("sleep test done");
    failsafe_select_in <= 2'h0;
    init_in <= 1'h1;
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      direct_inputs <= seed[3:0];
      settle();
      `QSW_CHK({switch_out, fault_flag_n}, {seed[3:0], 1'h1})
    end
    seed = lfsr(seed);
    d = seed[7:4];
    direct_inputs <= 4'h0;
    send(3'h0, {8'h00, d});
    `QSW_CHK(switch_out, d)
    send(3'h3, 12'h07F);
    `QSW_CHK({rx[7:4], rx[2:0]}, {d, 3'h0})
    `QSW_CHK({low_trip_level, high_trip_level, trip_blank_time}, 7'h7F)
    send(3'h0, 12'h000);
    direct_inputs <= 4'hF;
    other_fault_in <= 4'h2;
    settle();
    `QSW_CHK({switch_out, fault_flag_n, mode_out}, {4'hD, 1'h0, mode_fault})
    other_fault_in <= 4'h0;
    over_temp_in <= 4'h4;
    settle();
    `QSW_CHK(switch_out, 4'hB)
    over_temp_in <= 4'h0;
    settle();
    `QSW_CHK(switch_out, 4'hB)
    direct_inputs <= 4'hB;
    settle();
    direct_inputs <= 4'hF;
    settle();
    `QSW_CHK(switch_out, 4'hF)
    send(3'h2, 12'h004);
    over_temp_in <= 4'h4;
    settle();
    `QSW_CHK(switch_out, 4'hB)
    over_temp_in <= 4'h0;
    settle();
    `QSW_CHK(switch_out, 4'hF)
    repeat (1500) @(posedge mclk);
    `QSW_CHK(mode_out, mode_normal)
    init_in <= 1'h0;
    settle();
    `QSW_CHK({mode_out, low_trip_level}, {mode_sleep, 3'h0})
    $display("normal test done");
    failsafe_select_in <= 2'h3;
    mode_req_in <= 1'h1;
    init_in <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      send(3'h3, 12'h07F);
      repeat (150) @(posedge mclk);
    end
    `QSW_CHK(mode_out, mode_normal)
    send(3'h1, 12'h001);
    repeat (600) @(posedge mclk);
    `QSW_CHK(mode_out, mode_normal)
    repeat (400) @(posedge mclk);
    `QSW_CHK({mode_out, dog_expired_flag}, {mode_failsafe, 1'h1})
    `QSW_CHK({low_trip_level, high_trip_level, trip_blank_time}, 7'h00)
    send(3'h0, 12'h00A);
    `QSW_CHK({switch_out, rx[2]}, {4'h5, 1'h1})
    for (int s = 3; s >= 1; s--) begin
      failsafe_select_in <= s[1:0];
      settle();
      `QSW_CHK(switch_out, fs_pat(s[1:0]))
    end
    mode_req_in <= 1'h0;
    init_in <= 1'h0;
    settle();
    `QSW_CHK({mode_out, dog_expired_flag}, {mode_sleep, 1'h0})
    failsafe_select_in <= 2'h2;
    mode_req_in <= 1'h1;
    init_in <= 1'h1;
    repeat (500) @(posedge mclk);
    `QSW_CHK({mode_out, switch_out}, {mode_failsafe, 4'h1})
    failsafe_select_in <= 2'h0;
    settle();
    `QSW_CHK({mode_out, dog_expired_flag}, {mode_normal, 1'h0})
    $display("fail-safe test done");
    final_report();
  end
endmodule
